//--- logic/status_bank.v
/*
 * Read-only status and identity register bank behind an AHB-Lite slave port.
 * Assumes all event, queue and command inputs come from logic on hclk;
 * event inputs are pulses or levels, flags latch them until read.
 */
`include "status_bank_regs.vh"

// Functional notes
// [RULE_01] Lower bit 7: bus master fatal error
// [RULE_02] Lower bit 6: external buffer lock error
// [RULE_03] Lower bit 5: external buffer stall error
// [RULE_04] Lower bit 4: buffer near-stall warning
// [RULE_05] Lower bit 3: buffer overwrite warning
// [RULE_06] Lower bit 2: buffer initial warning
// [RULE_07] Lower bits 1, 0: scratchpad, event_notice_queue overflow
// [RULE_08] Upper bit 5: bridge discard timer expired
// [RULE_09] Upper bit 4: channel memory discard timeout
// [RULE_10] Upper bit 3: data memory discard timeout
// [RULE_11] Upper bit 2: bridge protocol error
// [RULE_12] Upper bit 1: channel memory protocol error
// [RULE_13] Upper bit 0: data memory protocol error
// [RULE_14] Eight-bit silicon revision register
// [RULE_15] Sixteen-bit part code, low byte first
// [RULE_16] One queue-busy flag per target region
// [RULE_17] Queue status bits 7:3 read zero
// [RULE_18] Bit 5: pause pending until frame
// [RULE_19] Bit 4: start pending until frame
// [RULE_20] Bits 3:0 show paused or started
// [RULE_21] Commands take effect at frame boundary
// [RULE_22] Writes to the bank are ignored
module status_bank #(
   parameter [7:0] REVISION  = 8'h0a,
   parameter [7:0] PART_LOW  = 8'h3c,
   parameter [7:0] PART_HIGH = 8'h5a
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        master_fatal_event,
   input  wire        buffer_lock_event,
   input  wire        buffer_stall_error_event,
   input  wire        buffer_stall_warning_event,
   input  wire        buffer_overwrite_event,
   input  wire        buffer_initial_event,
   input  wire        scratchpad_overflow_event,
   input  wire        event_notice_queue_overflow_event,
   input  wire        clock_failsafe_flag,
   input  wire        clock_fallback_flag,
   input  wire        bridge_timeout_event,
   input  wire        channel_mem_timeout_event,
   input  wire        data_mem_timeout_event,
   input  wire        bridge_protocol_event,
   input  wire        channel_mem_protocol_event,
   input  wire        data_mem_protocol_event,
   input  wire        bridge_queue_flag,
   input  wire        channel_mem_queue_flag,
   input  wire        data_mem_queue_flag,
   input  wire        start_cmd,
   input  wire        pause_cmd,
   input  wire        frame_boundary,
   output wire        channel_switching_enabled
);

   // Maps a byte address onto a register index
   function [`IDX_WIDTH-1:0] reg_index;
      input [31:0] addr;
      begin
         reg_index = addr[`IDX_WIDTH+`IDX_LSB-1:`IDX_LSB];
      end
   endfunction

   // True when the address falls on a mapped, word-aligned register
   function is_reg;
      input [31:0] addr;
      input [`IDX_WIDTH-1:0] idx;
      begin
         is_reg = (addr[31:`IDX_WIDTH+`IDX_LSB] == 18'h00000)
                  && (addr[`IDX_LSB-1:0] == 2'h0)
                  && (reg_index(addr) == idx);
      end
   endfunction

   wire [7:0] low_events;
   wire [5:0] high_events;
   wire [7:0] system_errors_low;
   wire [5:0] high_latched;
   wire [7:0] system_errors_high;
   wire [7:0] target_queue_status;
   wire [7:0] channel_switching_status;
   wire       start_pending_flag;
   wire       pause_pending_flag;
   wire [3:0] channel_switching_state;
   wire       read_take;
   wire       clear_low;
   wire       clear_high;
   reg  [7:0] read_byte;
   reg  [31:0] next_hrdata;

   assign low_events[`BIT_MASTER_FATAL]  = master_fatal_event;          // RULE_01
   assign low_events[`BIT_BUF_LOCK]      = buffer_lock_event;           // RULE_02
   assign low_events[`BIT_BUF_STALL_ERR] = buffer_stall_error_event;    // RULE_03
   assign low_events[`BIT_BUF_STALL_WARN] = buffer_stall_warning_event; // RULE_04
   assign low_events[`BIT_BUF_OVERWRITE] = buffer_overwrite_event;      // RULE_05
   assign low_events[`BIT_BUF_INITIAL]   = buffer_initial_event;        // RULE_06
   assign low_events[`BIT_SCRATCH_OVF]   = scratchpad_overflow_event;   // RULE_07
   assign low_events[`BIT_NOTIFY_OVF]    = event_notice_queue_overflow_event; // RULE_07

   assign high_events[`BIT_BRIDGE_TMO]   = bridge_timeout_event;        // RULE_08
   assign high_events[`BIT_CHMEM_TMO]    = channel_mem_timeout_event;   // RULE_09
   assign high_events[`BIT_DMEM_TMO]     = data_mem_timeout_event;      // RULE_10
   assign high_events[`BIT_BRIDGE_PROTO] = bridge_protocol_event;       // RULE_11
   assign high_events[`BIT_CHMEM_PROTO]  = channel_mem_protocol_event;  // RULE_12
   assign high_events[`BIT_DMEM_PROTO]   = data_mem_protocol_event;     // RULE_13

   // Only a word read takes a register; writes never touch the bank
   assign read_take = hsel & hready & (htrans == `HTRANS_NONSEQ)
                      & ~hwrite & (hsize == `HSIZE_WORD); // RULE_22

   // Reading an error register clears it; a late event still sets
   assign clear_low  = read_take & is_reg(haddr, `IDX_ERRORS_LOW);
   assign clear_high = read_take & is_reg(haddr, `IDX_ERRORS_HIGH);

   sticky_flags #(
      .WIDTH (8)
   ) u_low_flags (
      .hclk    (hclk),
      .hresetn (hresetn),
      .events  (low_events),
      .clear   (clear_low),
      .flags   (system_errors_low)
   );

   sticky_flags #(
      .WIDTH (`HIGH_LATCH_WIDTH)
   ) u_high_flags (
      .hclk    (hclk),
      .hresetn (hresetn),
      .events  (high_events),
      .clear   (clear_high),
      .flags   (high_latched)
   );

   // Clock indicators are owned by the clock logic and only mirrored here
   assign system_errors_high = {clock_failsafe_flag, clock_fallback_flag, high_latched};

   switch_control u_switch (
      .hclk                    (hclk),
      .hresetn                 (hresetn),
      .start_cmd               (start_cmd),
      .pause_cmd               (pause_cmd),
      .frame_boundary          (frame_boundary),
      .start_pending_flag      (start_pending_flag),
      .pause_pending_flag      (pause_pending_flag),
      .channel_switching_state (channel_switching_state)
   );

   assign target_queue_status = {`QUEUE_PAD, bridge_queue_flag,
                                 channel_mem_queue_flag, data_mem_queue_flag}; // RULE_16 RULE_17

   assign channel_switching_status = {`SWITCH_PAD, pause_pending_flag,
                                      start_pending_flag, channel_switching_state}; // RULE_20

   assign channel_switching_enabled = (channel_switching_state == `STATE_STARTED);

   // Read multiplexer; unmapped addresses read zero
   always @* begin
      read_byte = `BYTE_RESET;
      if (is_reg(haddr, `IDX_ERRORS_LOW)) begin
         read_byte = system_errors_low;
      end else if (is_reg(haddr, `IDX_ERRORS_HIGH)) begin
         read_byte = system_errors_high;
      end else if (is_reg(haddr, `IDX_REVISION)) begin
         read_byte = REVISION; // RULE_14
      end else if (is_reg(haddr, `IDX_PART_LOW)) begin
         read_byte = PART_LOW; // RULE_15
      end else if (is_reg(haddr, `IDX_PART_HIGH)) begin
         read_byte = PART_HIGH; // RULE_15
      end else if (is_reg(haddr, `IDX_QUEUE_STATUS)) begin
         read_byte = target_queue_status;
      end else if (is_reg(haddr, `IDX_SWITCH_STATUS)) begin
         read_byte = channel_switching_status;
      end
   end

   always @* begin
      next_hrdata = hrdata;
      if (read_take) begin
         next_hrdata = {`REG_PAD, read_byte};
      end
   end

   // Data come from a flop loaded at the address phase, so no wait states
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `WORD_ZERO;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   // Every transfer completes at once with OKAY; write data are dropped
   assign hreadyout = 1'b1;
   assign hresp     = `HRESP_OKAY;

endmodule

//--- logic/status_bank_regs.vh
/*
 * Register map, field positions and codes of the status and identity bank.
 * Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
 */
`ifndef STATUS_BANK_REGS_VH
`define STATUS_BANK_REGS_VH

// Register indices; byte address is four times the index
`define IDX_ERRORS_LOW        12'h126
`define IDX_ERRORS_HIGH       12'h127
`define IDX_REVISION          12'h128
`define IDX_PART_LOW          12'h12a
`define IDX_PART_HIGH         12'h12b
`define IDX_QUEUE_STATUS      12'h12c
`define IDX_SWITCH_STATUS     12'h12d
`define IDX_WIDTH             12
`define IDX_LSB               2

// Lower system error bits
`define BIT_MASTER_FATAL      7
`define BIT_BUF_LOCK          6
`define BIT_BUF_STALL_ERR     5
`define BIT_BUF_STALL_WARN    4
`define BIT_BUF_OVERWRITE     3
`define BIT_BUF_INITIAL       2
`define BIT_SCRATCH_OVF       1
`define BIT_NOTIFY_OVF        0

// Upper system error bits
`define BIT_CLK_FAILSAFE      7
`define BIT_CLK_FALLBACK      6
`define BIT_BRIDGE_TMO        5
`define BIT_CHMEM_TMO         4
`define BIT_DMEM_TMO          3
`define BIT_BRIDGE_PROTO      2
`define BIT_CHMEM_PROTO       1
`define BIT_DMEM_PROTO        0
`define HIGH_LATCH_WIDTH      6

// Queue and switching status fields
`define QUEUE_PAD             5'h00
`define SWITCH_PAD            2'h0
`define STATE_PAUSED          4'h0
`define STATE_STARTED         4'h1

// Bus encodings and reset values
`define HTRANS_NONSEQ         2'h2
`define HSIZE_WORD            3'h2
`define HRESP_OKAY            1'b0
`define BYTE_RESET            8'h00
`define WORD_ZERO             32'h00000000
`define REG_PAD               24'h000000

`endif

//--- logic/sticky_flags.v
/*
 * Bank of sticky event flags, cleared as a whole by a one-cycle strobe.
 * Assumes events are one-cycle pulses or levels from logic on hclk.
 */
module sticky_flags #(
   parameter WIDTH = 8
) (
   input  wire             hclk,
   input  wire             hresetn,
   input  wire [WIDTH-1:0] events,
   input  wire             clear,
   output reg  [WIDTH-1:0] flags
);

   wire [WIDTH-1:0] next_flags;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
         // A set in the clearing cycle survives, so no event is lost
         assign next_flags[i] = events[i] | (flags[i] & ~clear);
      end
   endgenerate

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= {WIDTH{1'b0}};
      end else begin
         flags <= next_flags;
      end
   end

endmodule

//--- logic/switch_control.v
/*
 * Start and pause of virtual channel switching, applied at frame boundaries.
 * Assumes command and frame strobes are one-cycle pulses on hclk.
 */
`include "status_bank_regs.vh"

module switch_control (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       start_cmd,
   input  wire       pause_cmd,
   input  wire       frame_boundary,
   output reg        start_pending_flag,
   output reg        pause_pending_flag,
   output reg  [3:0] channel_switching_state
);

   reg       next_start;
   reg       next_pause;
   reg [3:0] next_state;

   always @* begin
      next_start = start_pending_flag;
      next_pause = pause_pending_flag;
      next_state = channel_switching_state;
      // The boundary consumes what was pending before this cycle
      if (frame_boundary) begin // RULE_21
         if (pause_pending_flag) begin
            next_state = `STATE_PAUSED; // RULE_18
         end else if (start_pending_flag) begin
            next_state = `STATE_STARTED;
         end
         next_start = 1'b0;
         next_pause = 1'b0;
      end
      // A new command replaces the opposite one still waiting
      if (start_cmd) begin
         next_start = 1'b1; // RULE_19
         next_pause = 1'b0;
      end else if (pause_cmd) begin
         next_pause = 1'b1; // RULE_18
         next_start = 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_pending_flag      <= 1'b0;
         pause_pending_flag      <= 1'b0;
         channel_switching_state <= `STATE_PAUSED;
      end else begin
         start_pending_flag      <= next_start;
         pause_pending_flag      <= next_pause;
         channel_switching_state <= next_state; // RULE_20
      end
   end

endmodule

//--- verification/host_master.sv
/* Host side: an AHB-Lite master issuing single word transfers.
   Assumes tasks are entered just after a rising edge of hclk. */
module host_master (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel = 1'b0,
   output logic [31:0]      haddr = 32'h0,
   output logic [1:0]       htrans = 2'h0,
   output logic             hwrite = 1'b0,
   output logic [2:0]       hsize = 3'h2,
   output logic [31:0]      hwdata = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Select stays up between transfers so no signal is set twice in one step
   // Waits as long as the slave stalls; only the bench's own timeout ends a hang
   task automatic xfer(input logic w, input logic [31:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hwdata <= ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'ha5c3, a[15:0]};
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
endmodule

//--- verification/status_bank_monitor.sv
/* Assertions on the status bank's bus and switching ports.
   Assumes a single AHB-Lite slave, so hready is hreadyout. */
module status_bank_monitor #(
   parameter [7:0] REVISION = 8'h0a,
   parameter [7:0] PART_LOW = 8'h3c
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        master_fatal_event,
   input wire logic        bridge_queue_flag,
   input wire logic        channel_mem_queue_flag,
   input wire logic        data_mem_queue_flag,
   input wire logic        frame_boundary,
   input wire logic        channel_switching_enabled
);
   timeunit 1ns;
   timeprecision 1ps;
   wire rd = hsel && hready && htrans == 2'h2 && !hwrite && hsize == 3'h2;
   wire wr = hsel && hready && htrans == 2'h2 && hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_always: assert property (hreadyout && !hresp)
      else $error("slave stalled or erred");
   a_upper_zero: assert property (rd |=> hrdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_revision_read: assert property (rd && haddr == 32'h4a0 |=> hrdata[7:0] == REVISION)
      else $error("revision wrong");
   a_part_low: assert property (rd && haddr == 32'h4a8 |=> hrdata[7:0] == PART_LOW)
      else $error("part code low wrong");
   a_queue_live: assert property (rd && haddr == 32'h4b0 |=> hrdata[7:0] ==
      {5'h00, $past(bridge_queue_flag), $past(channel_mem_queue_flag),
       $past(data_mem_queue_flag)})
      else $error("queue status wrong");
   a_fatal_latched: assert property (master_fatal_event ##1 (rd && haddr == 32'h498)
      |=> hrdata[7])
      else $error("fatal flag lost");
   a_write_ignored: assert property (wr |=> $stable(hrdata))
      else $error("write changed read data");
   a_frame_switch: assert property ($changed(channel_switching_enabled)
      |-> $past(frame_boundary))
      else $error("switching changed off frame");
   c_switch_read: cover property (rd && haddr == 32'h4b4);
   c_enable_rise: cover property ($rose(channel_switching_enabled));
   c_write_seen: cover property (wr);
endmodule

bind status_bank status_bank_monitor #(.REVISION(REVISION), .PART_LOW(PART_LOW)) i_mon (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hreadyout,
   .hresp, .hrdata, .master_fatal_event, .bridge_queue_flag, .channel_mem_queue_flag,
   .data_mem_queue_flag, .frame_boundary, .channel_switching_enabled);

//--- verification/tb_top.sv
/* Self-checking bench for the status bank, with random event traffic.
   Assumes the host model and the checker bound to the bank. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, en;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, d, r;
   logic [31:0] lf = 32'ha77f;
   logic [7:0]  lo = 8'h00;
   logic [5:0]  hi = 6'h00;
   logic [1:0]  cf = 2'h0;
   logic [2:0]  q = 3'h0;
   logic [2:0]  cmd = 3'h0;
   int          err_total = 0;
   int          check_count = 0;
   int          cyc = 0;

   host_master i_host_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));
   status_bank i_status_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .master_fatal_event(lo[7]), .buffer_lock_event(lo[6]), .buffer_stall_error_event(lo[5]),
      .buffer_stall_warning_event(lo[4]), .buffer_overwrite_event(lo[3]),
      .buffer_initial_event(lo[2]), .scratchpad_overflow_event(lo[1]),
      .event_notice_queue_overflow_event(lo[0]), .clock_failsafe_flag(cf[1]),
      .clock_fallback_flag(cf[0]), .bridge_timeout_event(hi[5]),
      .channel_mem_timeout_event(hi[4]), .data_mem_timeout_event(hi[3]),
      .bridge_protocol_event(hi[2]), .channel_mem_protocol_event(hi[1]),
      .data_mem_protocol_event(hi[0]), .bridge_queue_flag(q[2]),
      .channel_mem_queue_flag(q[1]), .data_mem_queue_flag(q[0]), .start_cmd(cmd[2]),
      .pause_cmd(cmd[1]), .frame_boundary(cmd[0]), .channel_switching_enabled(en));

   initial begin
      forever #50 hclk = ~hclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] pad(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] v;
      i_host_master.xfer(1'b0, a, v);
      chk(v, e);
   endtask

   // Command pulse for one cycle, then the status byte and enable level
   task automatic sw(input logic [2:0] c, input logic [7:0] e);
      cmd <= c;
      @(posedge hclk);
      cmd <= 3'h0;
      rdc(32'h4b4, pad(e));
      chk({31'h0, en}, {31'h0, e[0]});
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         summarize;
      end
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(32'h4a0, pad(8'h0a));
      rdc(32'h4a8, pad(8'h3c));
      rdc(32'h4ac, pad(8'h5a));
      rdc(32'h4a4, 32'h0);
      rdc(32'h4b4, 32'h0);
      // First pass sets every source at once, the rest are random
      for (int i = 0; i < 20; i++) begin
         lf = lfsr(lf);
         r = (i == 0) ? 32'hffffffff : lf;
         lo <= r[7:0];
         hi <= r[13:8];
         cf <= r[15:14];
         q <= r[18:16];
         @(posedge hclk);
         lo <= 8'h00;
         hi <= 6'h00;
         rdc(32'h498, pad(r[7:0]));
         rdc(32'h498, 32'h0);
         rdc(32'h49c, pad({r[15:14], r[13:8]}));
         rdc(32'h49c, pad({r[15:14], 6'h00}));
         rdc(32'h4b0, pad({5'h00, r[18:16]}));
      end
      lo <= 8'h80;
      @(posedge hclk);
      lo <= 8'h00;
      i_host_master.xfer(1'b1, 32'h498, d);
      i_host_master.xfer(1'b1, 32'h4a0, d);
      i_host_master.xfer(1'b1, 32'h4b4, d);
      rdc(32'h498, pad(8'h80));
      rdc(32'h4a0, pad(8'h0a));
      // Event in the cycle that takes the read: the set must win over the clear
      lo <= 8'h01;
      rdc(32'h498, 32'h0);
      lo <= 8'h00;
      rdc(32'h498, pad(8'h01));
      sw(3'b100, 8'h10);
      sw(3'b001, 8'h01);
      sw(3'b010, 8'h21);
      sw(3'b001, 8'h00);
      sw(3'b100, 8'h10);
      sw(3'b010, 8'h20);
      sw(3'b001, 8'h00);
      sw(3'b110, 8'h10);
      sw(3'b001, 8'h01);
      // Pause with a frame in the same cycle stays pending for the next frame
      sw(3'b011, 8'h21);
      sw(3'b001, 8'h00);
      summarize;
   end
endmodule
